// File: logic/eag_regs.svh
// Register indexes, field positions and reset values of the address generator.
// Assumes a 32-bit Avalon-MM slave whose byte address is four times the index.
`ifndef EAG_REGS_SVH
`define EAG_REGS_SVH

// ----------------------------------------
// Register indexes
// ----------------------------------------
`define MODE_CTRL_IDX   10'h046
`define X_START_IDX     10'h048
`define X_END_IDX       10'h04a
`define Y_START_IDX     10'h04c
`define Y_END_IDX       10'h04e
`define BREV_CTRL_IDX   10'h050
`define LAST_EA_IDX     10'h060

// ----------------------------------------
// Field positions
// ----------------------------------------
`define XCIRC_EN_BIT    15
`define YCIRC_EN_BIT    14
`define BWM_LSB         8
`define YWM_LSB         4
`define XWM_LSB         0
`define BITREV_ENABLE_BIT        15
`define SEL_OFF         4'hf
`define NEAR_BITS       13

// ----------------------------------------
// Reset values
// ----------------------------------------
`define MODE_CTRL_RST   16'h0000
`define START_RST       16'h0000
`define END_RST         16'h0001
`define BREV_CTRL_RST   16'h0000
`define MODE_CTRL_MASK  16'hcfff

`endif

// File: logic/eag_pkg.sv
// Types shared by the address generator and its bench.
// Assumes decode supplies one request per unit per clock.
package eag_pkg;

	typedef enum logic [2:0] {
		am_reg_direct  = 3'h0,
		am_indirect    = 3'h1,
		am_post_mod    = 3'h2,
		am_pre_mod     = 3'h3,
		am_reg_offset  = 3'h4,
		am_lit_offset  = 3'h5,
		am_file_direct = 3'h6,
		am_literal     = 3'h7
	} addr_mode_e;

	typedef struct packed {
		logic        valid;
		addr_mode_e  mode;
		logic [3:0]  ptr_idx;
		logic [15:0] ptr_val;
		logic [15:0] off_val;
		logic [15:0] step;
		logic [9:0]  lit;
		logic        lit_wide;
		logic [15:0] file_addr;
		logic        copy_insn;
		logic        program_space;
		logic        mac_word_read;
		logic        result_to_default_working_register;
		logic        multiply;
	} agu_req_s;

	typedef struct packed {
		logic        ea_valid;
		logic [15:0] ea;
		logic        operand_valid;
		logic [15:0] operand;
		logic        wb_valid;
		logic [3:0]  wb_idx;
		logic [15:0] wb_val;
		logic        file_acc;
		logic        result_to_file;
		logic        refused;
	} agu_rsp_s;

endpackage

// File: logic/circ_fix.sv
// Circular buffer boundary correction for one address.
// Assumes start is even and end is odd, so the length is whole words.
`timescale 1ns/1ns
module circ_fix (
	input  wire logic [15:0] addr,
	input  wire logic [15:0] lo,
	input  wire logic [15:0] hi,
	output logic      [15:0] fixed
);
	logic [15:0] len;

	assign len = 16'(hi - lo + 16'h0001);

	// Bounds are checked by magnitude so a step may jump past them
	always_comb begin
		if (addr > hi)
			fixed = 16'(addr - len);
		else if (addr < lo)
			fixed = 16'(addr + len);
		else
			fixed = addr;
	end
endmodule

// File: logic/bitrev_step.sv
// Reverse-carry increment of a word pointer by a pivot.
// Assumes word data: the pivot counts words and bit 0 stays clear.
`timescale 1ns/1ns
module bitrev_step (
	input  wire logic [15:0] addr,
	input  wire logic [14:0] pivot,
	output logic      [15:0] next_addr
);
	logic [15:0] ra;
	logic [15:0] rp;
	logic [15:0] sum;

	assign ra = {<<{addr}};
	assign rp = {<<{{pivot, 1'b0}}};
	assign sum = 16'(ra + rp);
	assign next_addr = {<<{sum}} & 16'hfffe;
endmodule

// File: logic/effective_address_generator.sv
// Effective address generator: an X and a Y unit plus their control registers.
// Assumes decode on ref_clk presents requests; registers over Avalon-MM.
//
// Overview of operation
// [RL1] Separate X and Y units, independent
// [RL2] Y unit: multiply-accumulate word reads only
// [RL3] Linear, circular, bit-reversed sequencing supported
// [RL4] Bit-reversal never on program-space addresses
// [RL5] File address: 13 bits, low 8192 bytes
// [RL6] File ops use working register zero
// [RL7] Copy instruction reaches whole data space
// [RL8] Three-operand: register first, register/memory/literal second
// [RL9] Direct, indirect, post, pre modes, literals
// [RL10] Register direct forms no address
// [RL11] Post-modify: use pointer, then step it
// [RL12] Pre-modify: step pointer, then use it
// [RL13] Register offset: pointer plus offset register
// [RL14] Literal offset: pointer plus instruction literal
// [RL15] File direct: address from instruction only
// [RL16] X circular needs enable and select not 15
// [RL17] Y circular needs enable and select not 15
// [RL18] Corrected pointer written back only pre/post
// [RL19] Bit-reverse needs select, enable, increment mode
// [RL20] Address latched at end of request cycle
`timescale 1ns/1ns
`include "eag_regs.svh"
module effective_address_generator (
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	input  wire logic [11:0]       address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	input  eag_pkg::agu_req_s      x_req,
	input  eag_pkg::agu_req_s      y_req,
	output eag_pkg::agu_rsp_s      x_rsp,
	output eag_pkg::agu_rsp_s      y_rsp
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0]        mode_ctrl;
		logic [15:0]        xs;
		logic [15:0]        xe;
		logic [15:0]        ys;
		logic [15:0]        ye;
		logic [15:0]        brev;
		logic [15:0]        last_ea;
		logic               waitreq;
		logic [31:0]        rdata;
		eag_pkg::agu_rsp_s  x_rsp;
		eag_pkg::agu_rsp_s  y_rsp;
	} state_s;

	state_s st;
	state_s next_st;

	logic [15:0] x_cand;
	logic [15:0] y_cand;
	logic [15:0] x_fixed;
	logic [15:0] y_fixed;
	logic [15:0] x_brev;
	logic        x_circ;
	logic        y_circ;
	logic        x_bitrev;
	logic [9:0]  idx;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic is_step_mode(input eag_pkg::addr_mode_e m);
		return (m == eag_pkg::am_post_mod) || (m == eag_pkg::am_pre_mod);
	endfunction

	function automatic logic is_ind_mode(input eag_pkg::addr_mode_e m);
		return is_step_mode(m) || (m == eag_pkg::am_reg_offset) || (m == eag_pkg::am_lit_offset);
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
	                                       input logic [3:0] be);
		logic [15:0] v;
		v = old;
		if (be[0])
			v[7:0] = wd[7:0];
		if (be[1])
			v[15:8] = wd[15:8];
		return v;
	endfunction

	function automatic eag_pkg::agu_rsp_s calc(input eag_pkg::agu_req_s r,
	                                           input logic [15:0] cand,
	                                           input logic [15:0] fixed,
	                                           input logic circ,
	                                           input logic brev,
	                                           input logic [15:0] bval,
	                                           input logic is_y);
		eag_pkg::agu_rsp_s s;
		logic [15:0]       moved;
		s = '0;
		moved = circ ? fixed : cand;
		if (brev)
			moved = bval;
		// [RL2] Y unit gate
		s.refused = r.valid & is_y & ~(r.mac_word_read &
		            (r.mode == eag_pkg::am_indirect || is_ind_mode(r.mode)));
		s.wb_idx = r.ptr_idx;
		if (r.valid && !s.refused) begin
			case (r.mode)
				// [RL10] Register contents only
				eag_pkg::am_reg_direct: begin
					s.operand_valid = 1'b1;
					s.operand = r.ptr_val;
				end
				// [RL8] Short or long literal
				eag_pkg::am_literal: begin
					s.operand_valid = 1'b1;
					s.operand = r.lit_wide ? {6'h00, r.lit} : {11'h000, r.lit[4:0]};
				end
				eag_pkg::am_indirect: begin
					s.ea_valid = 1'b1;
					s.ea = r.ptr_val;
				end
				// [RL11] Use then modify
				eag_pkg::am_post_mod: begin
					s.ea_valid = 1'b1;
					s.ea = r.ptr_val;
					s.wb_valid = 1'b1;
					s.wb_val = moved;
				end
				// [RL12] Modify then use
				eag_pkg::am_pre_mod: begin
					s.ea_valid = 1'b1;
					s.ea = moved;
					s.wb_valid = 1'b1;
					s.wb_val = moved;
				end
				// [RL13] [RL14] [RL18] Offset sum, pointer kept
				eag_pkg::am_reg_offset, eag_pkg::am_lit_offset: begin
					s.ea_valid = 1'b1;
					s.ea = moved;
				end
				// [RL5] [RL7] [RL15] Address from instruction
				eag_pkg::am_file_direct: begin
					s.ea_valid = 1'b1;
					s.ea = r.copy_insn ? r.file_addr : {3'h0, r.file_addr[`NEAR_BITS-1:0]};
					// [RL6] Implicit working register zero
					s.file_acc = 1'b1;
					s.result_to_file = ~r.result_to_default_working_register & ~r.multiply;
				end
				default: begin
					s.ea_valid = 1'b0;
				end
			endcase
		end
		if (is_y) begin
			s.ea[0] = 1'b0;
			s.wb_val[0] = 1'b0;
		end
		return s;
	endfunction

	// ----------------------------------------
	// Address arithmetic
	// ----------------------------------------
	// [RL1] Each unit has its own adders and correction
	assign x_cand = 16'(x_req.ptr_val + (is_step_mode(x_req.mode) ? x_req.step : x_req.off_val));
	assign y_cand = 16'(y_req.ptr_val + (is_step_mode(y_req.mode) ? y_req.step : y_req.off_val));

	// [RL16] X circular qualification
	assign x_circ = st.mode_ctrl[`XCIRC_EN_BIT] &&
	                (st.mode_ctrl[`XWM_LSB+:4] != `SEL_OFF) &&
	                (st.mode_ctrl[`XWM_LSB+:4] == x_req.ptr_idx) && is_ind_mode(x_req.mode);

	// [RL17] Y circular qualification
	assign y_circ = st.mode_ctrl[`YCIRC_EN_BIT] &&
	                (st.mode_ctrl[`YWM_LSB+:4] != `SEL_OFF) &&
	                (st.mode_ctrl[`YWM_LSB+:4] == y_req.ptr_idx) && is_ind_mode(y_req.mode);

	// [RL4] [RL19] Bit-reverse only for data-space increments
	assign x_bitrev = st.brev[`BITREV_ENABLE_BIT] &&
	                  (st.mode_ctrl[`BWM_LSB+:4] != `SEL_OFF) &&
	                  (st.mode_ctrl[`BWM_LSB+:4] == x_req.ptr_idx) &&
	                  is_step_mode(x_req.mode) && !x_req.step[15] && (x_req.step != 16'h0000) &&
	                  !x_req.program_space;

	circ_fix u_x_circ (
		.addr  (x_cand),
		.lo    (st.xs),
		.hi    (st.xe),
		.fixed (x_fixed)
	);

	circ_fix u_y_circ (
		.addr  (y_cand),
		.lo    (st.ys),
		.hi    (st.ye),
		.fixed (y_fixed)
	);

	bitrev_step u_brev (
		.addr      (x_req.ptr_val),
		.pivot     (st.brev[14:0]),
		.next_addr (x_brev)
	);

	assign idx = address[11:2];

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		// [RL3] [RL9] [RL20] Result computed this cycle
		next_st.x_rsp = calc(x_req, x_cand, x_fixed, x_circ, x_bitrev, x_brev, 1'b0);
		next_st.y_rsp = calc(y_req, y_cand, y_fixed, y_circ, 1'b0, 16'h0000, 1'b1);
		if (next_st.x_rsp.ea_valid)
			next_st.last_ea = next_st.x_rsp.ea;
		next_st.waitreq = !((read || write) && st.waitreq);
		if ((read || write) && st.waitreq) begin
			next_st.rdata = 32'h0000_0000;
			if (address[1:0] == 2'h0) begin
				case (idx)
					`MODE_CTRL_IDX: next_st.rdata[15:0] = st.mode_ctrl;
					`X_START_IDX:   next_st.rdata[15:0] = st.xs;
					`X_END_IDX:     next_st.rdata[15:0] = st.xe;
					`Y_START_IDX:   next_st.rdata[15:0] = st.ys;
					`Y_END_IDX:     next_st.rdata[15:0] = st.ye;
					`BREV_CTRL_IDX: next_st.rdata[15:0] = st.brev;
					`LAST_EA_IDX:   next_st.rdata[15:0] = st.last_ea;
					default:        next_st.rdata = 32'h0000_0000;
				endcase
			end
		end
		if (write && !st.waitreq && address[1:0] == 2'h0) begin
			case (idx)
				`MODE_CTRL_IDX: next_st.mode_ctrl = merge(st.mode_ctrl, writedata, byteenable) &
				                                    `MODE_CTRL_MASK;
				`X_START_IDX:   next_st.xs = merge(st.xs, writedata, byteenable) & 16'hfffe;
				`X_END_IDX:     next_st.xe = merge(st.xe, writedata, byteenable) | 16'h0001;
				`Y_START_IDX:   next_st.ys = merge(st.ys, writedata, byteenable) & 16'hfffe;
				`Y_END_IDX:     next_st.ye = merge(st.ye, writedata, byteenable) | 16'h0001;
				`BREV_CTRL_IDX: next_st.brev = merge(st.brev, writedata, byteenable);
				default:        next_st.last_ea = next_st.last_ea;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
			st.mode_ctrl <= `MODE_CTRL_RST;
			st.xs <= `START_RST;
			st.xe <= `END_RST;
			st.ys <= `START_RST;
			st.ye <= `END_RST;
			st.brev <= `BREV_CTRL_RST;
			st.waitreq <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign readdata = st.rdata;
	assign waitrequest = st.waitreq;
	assign x_rsp = st.x_rsp;
	assign y_rsp = st.y_rsp;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	chk_y_refuse: assert property ( // [RL2]
		y_req.valid && !y_req.mac_word_read |=> y_rsp.refused && !y_rsp.ea_valid)
		else $error("Y unit served a non multiply-accumulate access");

	chk_prog_linear: assert property ( // [RL4]
		x_req.valid && x_req.program_space && x_req.mode == eag_pkg::am_post_mod && !x_circ
		|=> x_rsp.wb_valid && x_rsp.wb_val == $past(x_cand))
		else $error("Program space pointer not stepped linearly");

	chk_near_addr: assert property ( // [RL5]
		x_req.valid && x_req.mode == eag_pkg::am_file_direct && !x_req.copy_insn
		|=> x_rsp.ea == {3'h0, $past(x_req.file_addr[12:0])})
		else $error("Near file address not limited to 13 bits");

	chk_copy_full: assert property ( // [RL7]
		x_req.valid && x_req.mode == eag_pkg::am_file_direct && x_req.copy_insn
		|=> x_rsp.ea_valid && x_rsp.ea == $past(x_req.file_addr))
		else $error("Copy instruction address truncated");

	chk_direct_none: assert property ( // [RL10]
		x_req.valid && x_req.mode == eag_pkg::am_reg_direct
		|=> !x_rsp.ea_valid && x_rsp.operand_valid && x_rsp.operand == $past(x_req.ptr_val))
		else $error("Register direct formed an address");

	chk_post_ea: assert property ( // [RL11]
		x_req.valid && x_req.mode == eag_pkg::am_post_mod
		|=> x_rsp.ea == $past(x_req.ptr_val) && x_rsp.wb_valid)
		else $error("Post-modify used the stepped pointer");

	chk_pre_ea: assert property ( // [RL12]
		x_req.valid && x_req.mode == eag_pkg::am_pre_mod |=> x_rsp.ea == x_rsp.wb_val)
		else $error("Pre-modify address differs from write-back");

	chk_offset_sum: assert property ( // [RL13]
		x_req.valid && x_req.mode == eag_pkg::am_reg_offset && !x_circ
		|=> x_rsp.ea == 16'($past(x_req.ptr_val) + $past(x_req.off_val)))
		else $error("Register offset sum wrong");

	chk_offset_no_wb: assert property ( // [RL18]
		x_req.valid && x_req.mode inside {eag_pkg::am_reg_offset, eag_pkg::am_lit_offset}
		|=> !x_rsp.wb_valid)
		else $error("Offset mode wrote the pointer back");

	chk_circ_bound: assert property ( // [RL16]
		x_circ && x_req.valid && x_req.mode == eag_pkg::am_pre_mod && !x_bitrev
		&& st.xs <= st.xe && x_cand >= 16'(st.xs - (st.xe - st.xs + 16'h0001))
		&& x_cand <= 16'(st.xe + (st.xe - st.xs + 16'h0001)) && $stable(st.xs) && $stable(st.xe)
		|=> x_rsp.wb_val >= $past(st.xs) && x_rsp.wb_val <= $past(st.xe))
		else $error("Circular pointer left its buffer");

	chk_x_linear: assert property ( // [RL16]
		x_req.valid && x_req.mode == eag_pkg::am_post_mod && !st.mode_ctrl[`XCIRC_EN_BIT] && !x_bitrev
		|=> x_rsp.wb_val == 16'($past(x_req.ptr_val) + $past(x_req.step)))
		else $error("X pointer wrapped with circular mode off");

	chk_y_wrap: assert property ( // [RL17]
		y_circ && y_req.valid && y_req.mac_word_read && y_req.mode == eag_pkg::am_post_mod
		&& y_cand > st.ye && !y_cand[0]
		|=> y_rsp.wb_val == 16'($past(y_cand) - ($past(st.ye) - $past(st.ys) + 16'h0001)))
		else $error("Y circular pointer not wrapped at its end");

	chk_bus_answer: assert property (
		(read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
		else $error("Bus answer not given after one wait cycle");

	cov_x_wrap: cover property (x_circ && x_req.valid && x_cand != x_fixed);
	cov_bitrev: cover property (x_bitrev && x_req.valid);
	cov_y_read: cover property (y_req.valid && y_req.mac_word_read ##1 y_rsp.ea_valid);
endmodule

// File: tb/decode_model.sv
// Decode and working register model feeding both address units.
// Assumes responses stand one clock after each request edge.
`timescale 1ns/1ns
module decode_model (
	input  wire logic         ref_clk,
	input  eag_pkg::agu_rsp_s x_rsp,
	input  eag_pkg::agu_rsp_s y_rsp,
	output eag_pkg::agu_req_s x_req,
	output eag_pkg::agu_req_s y_req
);
	logic [15:0] w [16];

	initial begin
		x_req = '0;
		y_req = '0;
		for (int i = 0; i < 16; i++) begin
			w[i] = 16'h0000;
		end
	end

	always @(posedge ref_clk) begin
		if (x_rsp.wb_valid === 1'b1)
			w[x_rsp.wb_idx] <= x_rsp.wb_val;
		if (y_rsp.wb_valid === 1'b1)
			w[y_rsp.wb_idx] <= y_rsp.wb_val;
	end

	// A write-back still pending from the last request lands first
	task automatic set_w(input logic [3:0] i, input logic [15:0] v);
		@(posedge ref_clk);
		@(posedge ref_clk);
		w[i] <= v;
	endtask

	// Two edges let a pending write-back land before the pointer is read
	task automatic issue(input logic is_y, input eag_pkg::agu_req_s r);
		@(posedge ref_clk);
		@(posedge ref_clk);
		r.ptr_val = w[r.ptr_idx];
		if (is_y)
			y_req <= r;
		else
			x_req <= r;
		@(posedge ref_clk);
		x_req.valid <= 1'b0;
		y_req.valid <= 1'b0;
	endtask
endmodule

// File: tb/testbench.sv
// Register bus and unit request bench for the effective address generator.
// Assumes the decode model drives the unit requests.
`timescale 1ns/1ns
module testbench;
	logic              ref_clk = 1'b0;
	logic              arst_n = 1'b0;
	logic [11:0]       address = 12'h000;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic [31:0]       writedata = 32'h00000000;
	logic [3:0]        byteenable = 4'h0;
	logic [31:0]       readdata;
	logic              waitrequest;
	eag_pkg::agu_req_s x_req;
	eag_pkg::agu_req_s y_req;
	eag_pkg::agu_rsp_s x_rsp;
	eag_pkg::agu_rsp_s y_rsp;
	eag_pkg::agu_rsp_s rs;
	eag_pkg::agu_req_s q;
	int                n_mismatch = 0;
	int                cmp_count = 0;
	logic [11:0]       ra [8] = '{12'h118, 12'h120, 12'h128, 12'h130, 12'h138, 12'h140, 12'h1fc, 12'h119};
	logic [15:0]       rv [8] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000};

	always #10 ref_clk = ~ref_clk;

	effective_address_generator effective_address_generator_i (.ref_clk(ref_clk), .arst_n(arst_n),
		.address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .x_req(x_req), .y_req(y_req), .x_rsp(x_rsp), .y_rsp(y_rsp));
	decode_model decode_model_i (.ref_clk(ref_clk), .x_rsp(x_rsp), .y_rsp(y_rsp), .x_req(x_req), .y_req(y_req));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic print_verdict();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic bus(input logic wr, input logic [11:0] a, input logic [15:0] d, input logic [3:0] be,
		output logic [15:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {16'h0000, d};
		byteenable <= be;
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (waitrequest !== 1'b0) begin
			n_mismatch++;
			print_verdict();
		end
		r = readdata[15:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] be = 4'h3);
		logic [15:0] r;
		bus(1'b1, a, d, be, r);
	endtask

	task automatic rd(input string name, input logic [11:0] a, input logic [15:0] e);
		logic [15:0] r;
		bus(1'b0, a, 16'h0000, 4'h3, r);
		check(name, r, e);
	endtask

	function automatic eag_pkg::agu_req_s mk(input eag_pkg::addr_mode_e m, input logic [3:0] i,
		input logic [15:0] off, input logic [15:0] st);
		mk = '0;
		mk.valid = 1'b1;
		mk.mode = m;
		mk.ptr_idx = i;
		mk.off_val = off;
		mk.step = st;
		mk.mac_word_read = 1'b1;
	endfunction

	task automatic op(input logic is_y, input eag_pkg::agu_req_s r, input logic [15:0] ea,
		input logic [15:0] wbv, input logic wbf);
		decode_model_i.issue(is_y, r);
		#1;
		rs = is_y ? y_rsp : x_rsp;
		check("ea", rs.ea, ea);
		check("wb_valid", {15'h0000, rs.wb_valid}, {15'h0000, wbf});
		check("wb_idx", {12'h000, rs.wb_idx}, {12'h000, r.ptr_idx});
		if (wbf)
			check("wb_val", rs.wb_val, wbv);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd("reset value", ra[i], rv[i]);
		end
		wr(12'h118, 16'hffff);
		rd("mode ctrl", 12'h118, 16'hcfff);
		wr(12'h120, 16'h1235);
		rd("x start", 12'h120, 16'h1234);
		wr(12'h128, 16'h1240);
		rd("x end", 12'h128, 16'h1241);
		wr(12'h120, 16'h00cd, 4'h1);
		rd("x start low lane", 12'h120, 16'h12cc);
		wr(12'h121, 16'hffff);
		rd("misaligned write", 12'h120, 16'h12cc);
		wr(12'h118, 16'h0fff);
		decode_model_i.set_w(4'h1, 16'h0100);
		op(1'b0, mk(eag_pkg::am_indirect, 4'h1, 16'h0000, 16'h0000), 16'h0100, 16'h0000, 1'b0);
		op(1'b0, mk(eag_pkg::am_post_mod, 4'h1, 16'h0000, 16'h0004), 16'h0100, 16'h0104, 1'b1);
		op(1'b0, mk(eag_pkg::am_pre_mod, 4'h1, 16'h0000, 16'hfffe), 16'h0102, 16'h0102, 1'b1);
		op(1'b0, mk(eag_pkg::am_reg_offset, 4'h1, 16'h0010, 16'h0000), 16'h0112, 16'h0000, 1'b0);
		op(1'b0, mk(eag_pkg::am_lit_offset, 4'h1, 16'h0006, 16'h0000), 16'h0108, 16'h0000, 1'b0);
		decode_model_i.issue(1'b0, mk(eag_pkg::am_reg_direct, 4'h1, 16'h0000, 16'h0000));
		#1;
		check("operand", x_rsp.operand, 16'h0102);
		check("ea_valid", {15'h0000, x_rsp.ea_valid}, 16'h0000);
		q = mk(eag_pkg::am_literal, 4'h0, 16'h0000, 16'h0000);
		q.lit = 10'h3ff;
		q.lit_wide = 1'b1;
		decode_model_i.issue(1'b0, q);
		#1;
		check("literal", x_rsp.operand, 16'h03ff);
		check("operand_valid", {15'h0000, x_rsp.operand_valid}, 16'h0001);
		q = mk(eag_pkg::am_file_direct, 4'h0, 16'h0000, 16'h0000);
		q.file_addr = 16'hf234;
		op(1'b0, q, 16'h1234, 16'h0000, 1'b0);
		check("to file", {14'h0000, rs.file_acc, rs.result_to_file}, 16'h0003);
		q.multiply = 1'b1;
		op(1'b0, q, 16'h1234, 16'h0000, 1'b0);
		check("multiply dest", {15'h0000, rs.result_to_file}, 16'h0000);
		q.multiply = 1'b0;
		q.copy_insn = 1'b1;
		op(1'b0, q, 16'hf234, 16'h0000, 1'b0);
		rd("last ea", 12'h180, 16'hf234);
		wr(12'h120, 16'h1000);
		wr(12'h128, 16'h100f);
		wr(12'h118, 16'h8ff2);
		decode_model_i.set_w(4'h2, 16'h100e);
		op(1'b0, mk(eag_pkg::am_post_mod, 4'h2, 16'h0000, 16'h0002), 16'h100e, 16'h1000, 1'b1);
		op(1'b0, mk(eag_pkg::am_pre_mod, 4'h2, 16'h0000, 16'hfffe), 16'h100e, 16'h100e, 1'b1);
		op(1'b0, mk(eag_pkg::am_reg_offset, 4'h2, 16'h0004, 16'h0000), 16'h1002, 16'h0000, 1'b0);
		q = mk(eag_pkg::am_post_mod, 4'h2, 16'h0000, 16'h0002);
		q.program_space = 1'b1;
		op(1'b0, q, 16'h100e, 16'h1000, 1'b1);
		decode_model_i.set_w(4'h3, 16'h100e);
		op(1'b0, mk(eag_pkg::am_post_mod, 4'h3, 16'h0000, 16'h0002), 16'h100e, 16'h1010, 1'b1);
		wr(12'h118, 16'h8fff);
		decode_model_i.set_w(4'h2, 16'h100e);
		op(1'b0, mk(eag_pkg::am_post_mod, 4'h2, 16'h0000, 16'h0002), 16'h100e, 16'h1010, 1'b1);
		wr(12'h130, 16'h2000);
		wr(12'h138, 16'h2007);
		wr(12'h118, 16'h4faf);
		decode_model_i.set_w(4'ha, 16'h2006);
		op(1'b1, mk(eag_pkg::am_post_mod, 4'ha, 16'h0000, 16'h0002), 16'h2006, 16'h2000, 1'b1);
		decode_model_i.set_w(4'ha, 16'h2006);
		op(1'b0, mk(eag_pkg::am_post_mod, 4'ha, 16'h0000, 16'h0002), 16'h2006, 16'h2008, 1'b1);
		q = mk(eag_pkg::am_post_mod, 4'ha, 16'h0000, 16'h0002);
		q.mac_word_read = 1'b0;
		op(1'b1, q, 16'h0000, 16'h0000, 1'b0);
		check("refused", {15'h0000, rs.refused}, 16'h0001);
		op(1'b1, mk(eag_pkg::am_reg_direct, 4'ha, 16'h0000, 16'h0000), 16'h0000, 16'h0000, 1'b0);
		check("refused mode", {15'h0000, rs.refused}, 16'h0001);
		wr(12'h118, 16'h03ff);
		wr(12'h140, 16'h8008);
		decode_model_i.set_w(4'h3, 16'h0000);
		op(1'b0, mk(eag_pkg::am_post_mod, 4'h3, 16'h0000, 16'h0002), 16'h0000, 16'h0010, 1'b1);
		op(1'b0, mk(eag_pkg::am_post_mod, 4'h3, 16'h0000, 16'h0002), 16'h0010, 16'h0008, 1'b1);
		q = mk(eag_pkg::am_post_mod, 4'h3, 16'h0000, 16'h0002);
		q.program_space = 1'b1;
		op(1'b0, q, 16'h0008, 16'h000a, 1'b1);
		op(1'b0, mk(eag_pkg::am_post_mod, 4'h3, 16'h0000, 16'hfffe), 16'h000a, 16'h0008, 1'b1);
		print_verdict();
	end
endmodule
